//--- design/rst_seq_pkg.sv
// constants shared by the reset sequencer and its bench
// assumes one 200 MHz system clock and an active-low power-on reset
package rst_seq_pkg;
  // timing in system clocks
  localparam int START_DELAY_CYCLES = 1024;
  localparam int DELAY_CNT_W = 11;
  localparam logic [7:0] OPTION_LOAD_RST = 8'h08;
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CMD_OFFSET = 2'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 2'h1;
  localparam logic [ADDR_W-1:0] OPTION_OFFSET = 2'h2;
  // command bits
  localparam int CMD_CLEAR_WATCHDOG_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  // status bits
  localparam int STAT_POWER_DOWN_BIT = 0;
  localparam int STAT_WD_EXPIRED_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_CHIP_RST_BIT = 3;
  localparam int STAT_CPU_RUN_BIT = 4;
  // register initial values
  localparam logic [7:0] BANK_SELECT_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_PRESCALE_RST = 8'h07;
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h08;
  localparam logic [7:0] INTERRUPT_CTRL_RST = 8'h00;
  localparam logic [3:0] EEPROM_CTRL_RST = 4'h8;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [3:0] STACK_TOP = 4'h0;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_OPTION,
    ST_START,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } seq_state_t;
endpackage

//--- design/pin_sync.sv
// two-stage synchroniser for the external reset pin
// assumes the pin is asynchronous to i_clk and active low
`timescale 1ns/1ps
module pin_sync
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // pin
  input wire logic i_external_reset_pin_n,
  // synchronised level, high while the pin is asserted
  output logic o_pin_active
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  always_comb
  begin
    sync_next.stage1 = ~i_external_reset_pin_n;
    sync_next.stage2 = sync_reg.stage1;
  end

  // assume asserted at power-on so release always goes through the sequence
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sync_reg <= '{stage1: 1'b1, stage2: 1'b1};
    else
      sync_reg <= sync_next;
  end

  assign o_pin_active = sync_reg.stage2;
endmodule // pin_sync

//--- design/delay_counter.sv
// loadable down-counter that times the option-load and start-up delays
// assumes i_load is a one-cycle pulse and i_count is at least one
`timescale 1ns/1ps
module delay_counter
#(
  parameter int CNT_W = 11
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_count,
  // status
  output logic o_busy,
  output logic o_done
);
  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
  } cnt_t;

  cnt_t cnt_reg;
  cnt_t cnt_next;

  if (CNT_W < 2)
  begin : g_width_check
    $error("delay_counter: CNT_W too small");
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_load)
    begin
      cnt_next.busy = 1'b1;
      cnt_next.cnt = i_count - 1'b1;
    end
    else if (cnt_reg.busy)
    begin
      if (cnt_reg.cnt == '0)
        cnt_next.busy = 1'b0;
      else
        cnt_next.cnt = cnt_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  // done marks the last counted cycle
  assign o_busy = cnt_reg.busy;
  assign o_done = cnt_reg.busy && (cnt_reg.cnt == '0);
endmodule // delay_counter

//--- design/mcu_reset_sequencer.sv
// reset sequencer: sources, cause flags, option-load and start-up delays
// assumes watchdog and wake inputs are single-cycle pulses on i_clk
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module mcu_reset_sequencer
#(
  parameter int CNT_W = rst_seq_pkg::DELAY_CNT_W
)
(
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // reset sources
  input wire logic i_external_reset_pin_n,
  input wire logic i_watchdog_expire,
  input wire logic i_wake,
  // register port
  input wire logic [rst_seq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rst_seq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rst_seq_pkg::DATA_W-1:0] o_rdata,
  // reset controls
  output logic o_chip_rst,
  output logic o_warm_rst,
  output logic o_pc_clear,
  output logic o_stack_reset,
  output logic o_watchdog_clear,
  output logic o_cpu_run,
  output logic o_sleeping,
  // cause flags
  output logic o_watchdog_expired_flag,
  output logic o_power_down_flag,
  // initial values, loaded while o_chip_rst is high
  output logic [12:0] o_pc_init,
  output logic [3:0] o_stack_init,
  output logic [7:0] o_bank_select_init,
  output logic [7:0] o_watchdog_prescale_init,
  output logic [7:0] o_port_init,
  output logic [7:0] o_timer_ctrl_init,
  output logic [7:0] o_interrupt_ctrl_init,
  output logic [3:0] o_eeprom_ctrl_init
);
  import rst_seq_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic wd_expired;
    logic power_down;
    logic warm;
    logic [7:0] option_len;
    logic [DATA_W-1:0] rdata;
  } seq_t;

  seq_t seq_reg;
  seq_t seq_next;

  logic pin_active;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_busy;
  logic cnt_done;
  logic cmd_clear;
  logic cmd_sleep;
  logic [7:0] option_eff;

  if (CNT_W < DELAY_CNT_W)
  begin : g_cnt_check
    $error("mcu_reset_sequencer: CNT_W cannot hold the start-up delay");
  end

  pin_sync u_pin_sync
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_external_reset_pin_n(i_external_reset_pin_n),
    .o_pin_active(pin_active)
  );

  delay_counter #(.CNT_W(CNT_W)) u_delay
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(cnt_load),
    .i_count(cnt_value),
    .o_busy(cnt_busy),
    .o_done(cnt_done)
  );

  assign cmd_clear = i_wr && (i_addr == CMD_OFFSET)
    && i_wdata[CMD_CLEAR_WATCHDOG_BIT];
  assign cmd_sleep = i_wr && (i_addr == CMD_OFFSET)
    && i_wdata[CMD_SLEEP_BIT];
  // a zero length would underflow the counter
  assign option_eff = (seq_reg.option_len == 8'h00) ? 8'h01
    : seq_reg.option_len;

  always_comb
  begin
    seq_next = seq_reg;
    seq_next.warm = 1'b0;
    cnt_load = 1'b0;
    cnt_value = CNT_W'(START_DELAY_CYCLES);
    if (i_wr && (i_addr == OPTION_OFFSET))
      seq_next.option_len = i_wdata;
    unique case (seq_reg.state)
      ST_HOLD:
      begin
        // pin held: stay in reset until the synchronised release
        if (!pin_active)
        begin
          seq_next.state = ST_OPTION;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(option_eff);
        end
      end
      ST_OPTION:
      begin
        if (pin_active)
          seq_next.state = ST_HOLD;
        else if (cnt_done)
        begin
          seq_next.state = ST_START;
          cnt_load = 1'b1;
        end
      end
      ST_START:
      begin
        if (pin_active)
          seq_next.state = ST_HOLD;
        else if (cnt_done)
          seq_next.state = ST_RUN;
      end
      ST_RUN:
      begin
        if (pin_active)
          seq_next.state = ST_HOLD; // flags unchanged
        else if (i_watchdog_expire)
        begin
          seq_next.state = ST_OPTION;
          seq_next.wd_expired = 1'b1;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(option_eff);
        end
        else if (cmd_sleep)
        begin
          // sleep wins over a clear in the same write
          seq_next.state = ST_SLEEP;
          seq_next.power_down = 1'b1;
          seq_next.wd_expired = 1'b0;
        end
        else if (cmd_clear)
        begin
          seq_next.power_down = 1'b0;
          seq_next.wd_expired = 1'b0;
        end
      end
      ST_SLEEP:
      begin
        if (pin_active)
        begin
          seq_next.state = ST_HOLD;
          seq_next.wd_expired = 1'b0;
          seq_next.power_down = 1'b1;
        end
        else if (i_watchdog_expire)
        begin
          // warm reset: no option load, no register initial values
          seq_next.state = ST_WAKE;
          seq_next.wd_expired = 1'b1;
          seq_next.power_down = 1'b1;
          seq_next.warm = 1'b1;
          cnt_load = 1'b1;
        end
        else if (i_wake)
        begin
          seq_next.state = ST_WAKE;
          cnt_load = 1'b1;
        end
      end
      ST_WAKE:
      begin
        if (pin_active)
          seq_next.state = ST_HOLD;
        else if (cnt_done)
          seq_next.state = ST_RUN;
      end
    endcase
    seq_next.rdata = '0;
    if (i_rd && (i_addr == STATUS_OFFSET))
    begin
      seq_next.rdata[STAT_POWER_DOWN_BIT] = seq_reg.power_down;
      seq_next.rdata[STAT_WD_EXPIRED_BIT] = seq_reg.wd_expired;
      seq_next.rdata[STAT_SLEEP_BIT] = (seq_reg.state == ST_SLEEP);
      seq_next.rdata[STAT_CHIP_RST_BIT] = o_chip_rst;
      seq_next.rdata[STAT_CPU_RUN_BIT] = o_cpu_run;
    end
    else if (i_rd && (i_addr == OPTION_OFFSET))
      seq_next.rdata = seq_reg.option_len;
  end

  // power-on clears both flags
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      seq_reg <= '{state: ST_HOLD, wd_expired: 1'b0, power_down: 1'b0,
        warm: 1'b0, option_len: OPTION_LOAD_RST, rdata: '0};
    else
      seq_reg <= seq_next;
  end

  // chip reset covers pin hold, option load and start-up delay
  assign o_chip_rst = (seq_reg.state == ST_HOLD)
    || (seq_reg.state == ST_OPTION)
    || (seq_reg.state == ST_START);
  assign o_warm_rst = seq_reg.warm;
  assign o_pc_clear = o_chip_rst || seq_reg.warm;
  assign o_stack_reset = o_chip_rst || seq_reg.warm;
  assign o_watchdog_clear = o_chip_rst
    || ((seq_reg.state == ST_RUN) && (cmd_clear || cmd_sleep));
  assign o_cpu_run = (seq_reg.state == ST_RUN);
  assign o_sleeping = (seq_reg.state == ST_SLEEP);
  assign o_watchdog_expired_flag = seq_reg.wd_expired;
  assign o_power_down_flag = seq_reg.power_down;
  assign o_rdata = seq_reg.rdata;

  // pointers, accumulator, table and timer counts get no load at all
  assign o_pc_init = PC_RST;
  assign o_stack_init = STACK_TOP;
  assign o_bank_select_init = BANK_SELECT_RST;
  assign o_watchdog_prescale_init = WATCHDOG_PRESCALE_RST;
  assign o_port_init = PORT_RST;
  assign o_timer_ctrl_init = TIMER_CTRL_RST;
  assign o_interrupt_ctrl_init = INTERRUPT_CTRL_RST;
  assign o_eeprom_ctrl_init = EEPROM_CTRL_RST;

  // helper: cycles spent in the start-up delay states
  logic [CNT_W:0] dly_cycles;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      dly_cycles <= '0;
    else if (seq_reg.state == ST_START || seq_reg.state == ST_WAKE)
      dly_cycles <= dly_cycles + 1'b1;
    else
      dly_cycles <= '0;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  chk_start_len: assert property (
    (seq_reg.state inside {ST_START, ST_WAKE}) && !pin_active
      && (seq_next.state == ST_RUN)
      |-> dly_cycles == (CNT_W+1)'(START_DELAY_CYCLES - 1))
    else $error("start-up delay is not 1024 clocks");

  chk_start_in_rst: assert property (
    (seq_reg.state == ST_START) |-> o_chip_rst && !o_cpu_run)
    else $error("start-up delay ran outside reset");

  chk_wd_run: assert property (
    (seq_reg.state == ST_RUN) && !pin_active && i_watchdog_expire
      |=> o_watchdog_expired_flag && (seq_reg.state == ST_OPTION)
      && $stable(o_power_down_flag))
    else $error("watchdog reset in running mishandled");

  chk_pin_run: assert property (
    (seq_reg.state == ST_RUN) && pin_active
      |=> $stable(o_watchdog_expired_flag) && $stable(o_power_down_flag)
      && o_chip_rst)
    else $error("pin reset changed the cause flags");

  chk_pin_sleep: assert property (
    (seq_reg.state == ST_SLEEP) && pin_active
      |=> !o_watchdog_expired_flag && o_power_down_flag && o_chip_rst)
    else $error("pin wake from sleep flags wrong");

  chk_warm_flags: assert property (
    (seq_reg.state == ST_SLEEP) && !pin_active && i_watchdog_expire
      |=> o_warm_rst && o_watchdog_expired_flag && o_power_down_flag
      && !o_chip_rst ##1 !o_warm_rst && !o_cpu_run)
    else $error("warm reset wrong");

  chk_warm_scope: assert property (
    o_warm_rst |-> !o_chip_rst && o_pc_clear && o_stack_reset
      && !o_watchdog_clear)
    else $error("warm reset touched chip reset");

  chk_sleep_flag: assert property (
    (seq_reg.state == ST_RUN) && !pin_active && !i_watchdog_expire
      && cmd_sleep |=> o_power_down_flag && o_sleeping)
    else $error("sleep did not set power-down flag");

  chk_clear_flag: assert property (
    (seq_reg.state == ST_RUN) && !pin_active && !i_watchdog_expire
      && cmd_clear && !cmd_sleep |=> !o_power_down_flag)
    else $error("clear did not drop power-down flag");

  chk_wd_cleared: assert property (
    o_chip_rst |-> o_watchdog_clear ##0 o_pc_clear)
    else $error("watchdog not held clear in reset");

  chk_pin_hold: assert property (
    pin_active |=> !o_cpu_run)
    else $error("cpu ran with pin asserted");

  cov_warm: cover property (
    (seq_reg.state == ST_SLEEP) && i_watchdog_expire ##1 o_warm_rst);
  cov_pin_wake: cover property (
    (seq_reg.state == ST_SLEEP) ##1 (seq_reg.state == ST_HOLD));
  cov_wd_run: cover property (
    (seq_reg.state == ST_RUN) ##1 (seq_reg.state == ST_OPTION));
  cov_run_after_start: cover property (
    (seq_reg.state == ST_START) ##1 (seq_reg.state == ST_RUN));
endmodule // mcu_reset_sequencer

//--- testbench/reset_partner.sv
// model of the external reset pin circuit and the on-chip watchdog
// assumes the bench raises requests just after rising edges
`timescale 1ns/1ps
module reset_partner
(
  // clock
  input wire logic i_clk,
  // requests from the bench
  input wire logic i_pin_req,
  input wire logic i_wd_req,
  // to the sequencer
  output logic o_external_reset_pin_n,
  output logic o_watchdog_expire
);
  logic wd_req_reg = 1'b0;
  logic pulse_reg = 1'b0;
  assign o_watchdog_expire = pulse_reg;
  // pin has a pull-up, so released reads high
  assign o_external_reset_pin_n = ~i_pin_req;
  // one overflow pulse per request, like a counter wrapping once
  always @(posedge i_clk)
  begin
    wd_req_reg <= i_wd_req;
    pulse_reg <= i_wd_req & ~wd_req_reg;
  end
endmodule // reset_partner

//--- testbench/mcu_reset_sequencer_bench.sv
// self-checking bench for the reset sequencer
// assumes the partner model drives the pin and the watchdog pulse
`timescale 1ns/1ps
module mcu_reset_sequencer_bench;
  import rst_seq_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic pin_req = 1'b0;
  logic wd_req = 1'b0;
  logic i_wake = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic pin_n, wd_exp, o_chip_rst, o_warm_rst, o_pc_clear, o_stack_reset;
  logic o_watchdog_clear, o_cpu_run, o_sleeping, o_wd_flag, o_pd_flag;
  logic [7:0] o_rdata, bank_i, pre_i, port_i, tmr_i, interrupt_control_reg_i;
  logic [12:0] pc_i;
  logic [3:0] stk_i, ee_i;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  always #2.5 i_clk = ~i_clk;

  reset_partner partner (.i_clk(i_clk), .i_pin_req(pin_req),
    .i_wd_req(wd_req), .o_external_reset_pin_n(pin_n),
    .o_watchdog_expire(wd_exp));

  mcu_reset_sequencer DUT (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_external_reset_pin_n(pin_n), .i_watchdog_expire(wd_exp),
    .i_wake(i_wake), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_chip_rst(o_chip_rst),
    .o_warm_rst(o_warm_rst), .o_pc_clear(o_pc_clear),
    .o_stack_reset(o_stack_reset), .o_watchdog_clear(o_watchdog_clear),
    .o_cpu_run(o_cpu_run), .o_sleeping(o_sleeping),
    .o_watchdog_expired_flag(o_wd_flag), .o_power_down_flag(o_pd_flag),
    .o_pc_init(pc_i), .o_stack_init(stk_i), .o_bank_select_init(bank_i),
    .o_watchdog_prescale_init(pre_i), .o_port_init(port_i),
    .o_timer_ctrl_init(tmr_i), .o_interrupt_ctrl_init(interrupt_control_reg_i),
    .o_eeprom_ctrl_init(ee_i));

  task automatic summarize();
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp,
    input string name);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(name, 16'(exp), 16'(o_rdata));
  endtask

  // cycles with the cpu held, counted from the current cycle
  task automatic run_wait(input int lo, input int hi, input string name);
    int n;
    n = 0;
    while (o_cpu_run !== 1'b1 && n < 3000)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    checked++;
    if (n < lo || n > hi)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, n);
    end
  endtask

  task automatic flags(input logic wd, input logic pd);
    chk("expired flag", 16'(wd), 16'(o_wd_flag));
    chk("power-down flag", 16'(pd), 16'(o_pd_flag));
  endtask

  task automatic wd_fire();
    @(posedge i_clk);
    wd_req <= 1'b1;
    repeat (2) @(posedge i_clk);
    wd_req <= 1'b0;
    #1;
  endtask

  // pin held 5 cycles, then released; delay timed from release
  task automatic pin_pulse();
    @(posedge i_clk);
    pin_req <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    chk("chip reset on pin", 16'h1, 16'(o_chip_rst));
    @(posedge i_clk);
    pin_req <= 1'b0;
    #1;
    run_wait(1025, 1036, "pin start-up");
  endtask

  task automatic wake_pulse();
    @(posedge i_clk);
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    #1;
    chk("chip reset in wake", 16'h0, 16'(o_chip_rst));
    run_wait(1024, 1024, "wake delay");
  endtask

  task automatic t_power_on();
    repeat (5) @(posedge i_clk);
    flags(1'b0, 1'b0);
    chk("chip reset", 16'h1, 16'(o_chip_rst));
    chk("wd clear", 16'h1, 16'(o_watchdog_clear));
    chk("pc init", 16'(PC_RST), 16'(pc_i));
    chk("stack init", 16'(STACK_TOP), 16'(stk_i));
    chk("bank init", 16'h00, 16'(bank_i));
    chk("prescale init", 16'h07, 16'(pre_i));
    chk("port init", 16'hFF, 16'(port_i));
    chk("timer init", 16'h08, 16'(tmr_i));
    chk("interrupt_control_reg init", 16'h00, 16'(interrupt_control_reg_i));
    chk("eeprom init", 16'h8, 16'(ee_i));
    i_nrst <= 1'b1;
    #1;
    run_wait(1032, 1040, "power-on delay");
    rd(OPTION_OFFSET, 8'h08, "option");
    rd(STATUS_OFFSET, 8'h10, "status");
    rd(2'h3, 8'h00, "unmapped");
    rd(CMD_OFFSET, 8'h00, "cmd read");
  endtask

  task automatic t_wd_run();
    wd_fire();
    chk("chip reset", 16'h1, 16'(o_chip_rst));
    flags(1'b1, 1'b0);
    chk("wd clear", 16'h1, 16'(o_watchdog_clear));
    chk("pc clear", 16'h1, 16'(o_pc_clear));
    run_wait(1032, 1032, "wd reset delay");
    wr(OPTION_OFFSET, 8'h01);
    rd(OPTION_OFFSET, 8'h01, "option");
  endtask

  task automatic t_sleep_wake();
    wr(CMD_OFFSET, 8'h02);
    chk("sleeping", 16'h1, 16'(o_sleeping));
    flags(1'b0, 1'b1);
    rd(STATUS_OFFSET, 8'h05, "status");
    wake_pulse();
    flags(1'b0, 1'b1);
  endtask

  task automatic t_warm();
    wr(CMD_OFFSET, 8'h02);
    wd_fire();
    chk("warm reset", 16'h1, 16'(o_warm_rst));
    chk("pc clear", 16'h1, 16'(o_pc_clear));
    chk("stack reset", 16'h1, 16'(o_stack_reset));
    chk("chip reset", 16'h0, 16'(o_chip_rst));
    chk("wd clear", 16'h0, 16'(o_watchdog_clear));
    flags(1'b1, 1'b1);
    @(posedge i_clk);
    #1;
    chk("warm pulse end", 16'h0, 16'(o_warm_rst));
    run_wait(1023, 1023, "warm delay");
  endtask

  task automatic t_pins();
    pin_pulse();
    flags(1'b1, 1'b1);
    wr(CMD_OFFSET, 8'h02);
    pin_pulse();
    flags(1'b0, 1'b1);
  endtask

  // second power-on reset in mid-run: flags must return to 0,0
  task automatic t_reset_again();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    flags(1'b0, 1'b0);
    chk("chip reset", 16'h1, 16'(o_chip_rst));
    @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    run_wait(1032, 1040, "reset again delay");
    rd(OPTION_OFFSET, 8'h08, "option after reset");
  endtask

  task automatic t_clear();
    wr(CMD_OFFSET, 8'h01);
    flags(1'b0, 1'b0);
    // both bits at once: sleep has to win
    wr(CMD_OFFSET, 8'h03);
    chk("sleeping", 16'h1, 16'(o_sleeping));
    flags(1'b0, 1'b1);
    wake_pulse();
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    t_power_on();
    t_wd_run();
    t_sleep_wake();
    t_warm();
    t_pins();
    t_reset_again();
    t_clear();
    summarize();
  end
endmodule // mcu_reset_sequencer_bench
